/* rtl/fm_ctrl_pkg.sv */
// Shared constants and types for the transmit deviation and interrupt control bank.
`default_nettype none
package fm_ctrl_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_TX_DEVIATION = 8'h0E;
   localparam logic [7:0] ADDR_PILOT_IRQ    = 8'h0F;
   localparam logic [7:0] ADDR_GROUP_FIRST  = 8'h10;
   localparam logic [7:0] ADDR_GROUP_LAST   = 8'h17;

   // Reset values of the deviation code and pilot gain fields.
   localparam logic [7:0] TX_DEVIATION_RESET = 8'h6C;
   localparam logic [3:0] PILOT_GAIN_RESET   = 4'h9;

   // Field positions inside the pilot gain and interrupt control register.
   localparam int UNDERRUN_CLEAR_BIT = 7;
   localparam int OVERRUN_CLEAR_BIT  = 6;
   localparam int PILOT_GAIN_MSB     = 5;
   localparam int PILOT_GAIN_LSB     = 2;
   localparam int GROUP_IRQ_EN_BIT   = 1;
   localparam int SCAN_IRQ_EN_BIT    = 0;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam real         PULSE_TIME_MS = 4.5;
   localparam real         CLK_PERIOD_NS = 20.0;
   localparam int unsigned PULSE_CYCLES  = int'(PULSE_TIME_MS * 1.0e6 / CLK_PERIOD_NS);

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed
   {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_type;

   typedef struct packed
   {
      logic       group_irq_en;
      logic       scan_irq_en;
      logic [3:0] pilot_gain;
      logic [7:0] tx_deviation;
   } config_type;

   typedef enum logic
   {
      PULSE_IDLE   = 1'b0,
      PULSE_ACTIVE = 1'b1
   } pulse_state_type;

endpackage

`default_nettype wire

/* rtl/irq_pulse_timer.sv */
// Timer that stretches start requests into fixed-length pulses and queues one request.
`timescale 1ns/100ps
`default_nettype none

module irq_pulse_timer
#(
   parameter int unsigned LENGTH = 4
)
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic start,
   output var  logic busy
);
   import fm_ctrl_pkg::*;

   localparam int CW = $clog2(LENGTH + 1);
   localparam logic [CW-1:0] LAST = CW'(LENGTH - 1);
   localparam logic [CW-1:0] ZERO = '0;

   pulse_state_type state;
   logic [CW-1:0]   count;
   logic            pending;

   // A request that lands during a pulse is held so that it still gets its own pulse.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pending <= 1'b0;
      else if (start && state == PULSE_ACTIVE)
         pending <= 1'b1;
      else if (state == PULSE_IDLE)
         pending <= 1'b0;
   end

   // Pulse state and cycle counter.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= PULSE_IDLE;
         count <= ZERO;
      end
      else
      begin
         unique case (state)
            PULSE_IDLE:
            begin
               count <= ZERO;
               if (start || pending)
                  state <= PULSE_ACTIVE;
            end
            PULSE_ACTIVE:
            begin
               if (count == LAST)
               begin
                  count <= ZERO;
                  state <= PULSE_IDLE;
               end
               else
                  count <= count + 1'b1;
            end
         endcase
      end
   end

   assign busy = (state == PULSE_ACTIVE);

   // A pulse goes on while the counter is short of its end and stops right at it.
   a_pulse_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
      busy |=> (busy == ($past(count) != LAST)))
      else $error("pulse counter ran past its end");

endmodule

`default_nettype wire

/* rtl/fm_tx_deviation_irq_control.sv */
// Transmit deviation, pilot gain, audio buffer flag clear and interrupt pulse control.
`timescale 1ns/100ps
`default_nettype none

module fm_tx_deviation_irq_control
#(
   parameter int unsigned PULSE_LEN = fm_ctrl_pkg::PULSE_CYCLES
)
(
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire fm_ctrl_pkg::reg_write_type reg_wr,
   input  wire logic                       tx_mode,
   input  wire logic                       group_load_toggle,
   input  wire logic                       rx_group_stored,
   input  wire logic                       scan_done,
   input  wire logic                       underrun_event,
   input  wire logic                       overrun_event,
   output var  fm_ctrl_pkg::config_type    cfg,
   output var  logic                       underrun_flag,
   output var  logic                       overrun_flag,
   output var  logic                       group_readable,
   output var  logic                       rx_int_out,
   output var  logic                       rx_int_oe,
   output var  logic                       tx_int_out,
   output var  logic                       tx_int_oe
);
   import fm_ctrl_pkg::*;

   // ****************************************************************
   // Register writes
   // ****************************************************************
   logic wr_dev;
   logic wr_ctl;
   logic wr_group;

   assign wr_dev   = reg_wr.en && reg_wr.addr == ADDR_TX_DEVIATION;
   assign wr_ctl   = reg_wr.en && reg_wr.addr == ADDR_PILOT_IRQ;
   assign wr_group = reg_wr.en && reg_wr.addr >= ADDR_GROUP_FIRST
                     && reg_wr.addr <= ADDR_GROUP_LAST;

   // Deviation code, pilot gain and the two interrupt enables in one process.
   // Keeping every field of the config in one process gives the output a single driver.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg.tx_deviation <= TX_DEVIATION_RESET;
         cfg.pilot_gain   <= PILOT_GAIN_RESET;
         cfg.group_irq_en <= 1'b0;
         cfg.scan_irq_en  <= 1'b0;
      end
      else
      begin
         if (wr_dev)
            cfg.tx_deviation <= reg_wr.data;
         if (wr_ctl)
         begin
            cfg.pilot_gain   <= reg_wr.data[PILOT_GAIN_MSB:PILOT_GAIN_LSB];
            cfg.group_irq_en <= reg_wr.data[GROUP_IRQ_EN_BIT];
            cfg.scan_irq_en  <= reg_wr.data[SCAN_IRQ_EN_BIT];
         end
      end
   end

   // ****************************************************************
   // Audio buffer flags
   // ****************************************************************
   logic clr_under;
   logic clr_over;

   assign clr_under = wr_ctl && reg_wr.data[UNDERRUN_CLEAR_BIT];
   assign clr_over  = wr_ctl && reg_wr.data[OVERRUN_CLEAR_BIT];

   // The clear bit acts only in the cycle of its write, and a new event in that cycle wins over it.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         underrun_flag <= 1'b0;
      else if (underrun_event)
         underrun_flag <= 1'b1;
      else if (clr_under)
         underrun_flag <= 1'b0;
   end

   // Overflow flag follows the same set-over-clear order.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         overrun_flag <= 1'b0;
      else if (overrun_event)
         overrun_flag <= 1'b1;
      else if (clr_over)
         overrun_flag <= 1'b0;
   end

   // ****************************************************************
   // Group load and readback gate
   // ****************************************************************
   logic load_prev;
   logic load_edge;

   assign load_edge = group_load_toggle != load_prev;

   // Remember the toggle level; either edge counts as a load.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         load_prev <= 1'b0;
      else
         load_prev <= group_load_toggle;
   end

   // Fresh host bytes stay hidden in transmit mode until the group is loaded.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         group_readable <= 1'b1;
      else if (tx_mode && load_edge)
         group_readable <= 1'b1;
      else if (tx_mode && wr_group)
         group_readable <= 1'b0;
      else if (!tx_mode)
         group_readable <= 1'b1;
   end

   // ****************************************************************
   // Interrupt pulse
   // ****************************************************************
   logic group_event;
   logic irq_start;
   logic pulse_busy;

   assign group_event = tx_mode ? load_edge : rx_group_stored;
   assign irq_start   = (cfg.group_irq_en && group_event)
                        || (cfg.scan_irq_en && scan_done);

   irq_pulse_timer
   #(
      .LENGTH (PULSE_LEN)
   )
   u_pulse
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .start   (irq_start),
      .busy    (pulse_busy)
   );

   // Only the pin of the current mode is driven; it idles high between pulses.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_int_out <= 1'b1;
         rx_int_oe  <= 1'b1;
         tx_int_out <= 1'b1;
         tx_int_oe  <= 1'b0;
      end
      else
      begin
         rx_int_out <= !pulse_busy;
         tx_int_out <= !pulse_busy;
         rx_int_oe  <= !tx_mode;
         tx_int_oe  <= tx_mode;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_deviation_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_dev |=> cfg.tx_deviation == $past(reg_wr.data))
      else $error("deviation code not stored");

   a_pilot_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_ctl |=> cfg.pilot_gain == $past(reg_wr.data[PILOT_GAIN_MSB:PILOT_GAIN_LSB]))
      else $error("pilot gain not stored");

   a_underrun_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clr_under && !underrun_event) |=> !underrun_flag)
      else $error("underflow flag not cleared");

   a_overrun_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clr_over && !overrun_event) |=> !overrun_flag)
      else $error("overflow flag not cleared");

   a_overrun_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (overrun_event || (overrun_flag && !clr_over)) |=> overrun_flag)
      else $error("overflow flag lost");

   a_group_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cfg.group_irq_en && group_event && !pulse_busy) |=> pulse_busy ##1 !rx_int_out)
      else $error("group event gave no pulse");

   a_scan_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cfg.scan_irq_en && scan_done && !pulse_busy) |-> ##2 (!tx_int_out && !rx_int_out))
      else $error("scan done gave no pulse");

   a_pin_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_mode [*2] |-> tx_int_oe && !rx_int_oe)
      else $error("interrupt on wrong pin");

   a_no_pulse_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!cfg.group_irq_en && !cfg.scan_irq_en && !pulse_busy && !u_pulse.pending)
      |=> !pulse_busy)
      else $error("pulse while disabled");

   a_readback_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (tx_mode && wr_group && !load_edge) |=> !group_readable)
      else $error("group readable before load");

endmodule

`default_nettype wire

/* tb/host_ctrl_model.sv */
// Host controller model that writes the control registers and flips the group load toggle.
`timescale 1ns/100ps
`default_nettype none

module host_ctrl_model
(
   input  wire logic                       clk_sys,
   output var  fm_ctrl_pkg::reg_write_type reg_wr,
   output var  logic                       group_load_toggle
);
   import fm_ctrl_pkg::*;

   // Nothing is requested at time zero.
   initial
   begin
      reg_wr = '0;
      group_load_toggle = 1'b0;
   end

   // The strobe stands for one edge. The released bus shows the inverse, so stale data never passes.
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      #1 reg_wr <= '{en: 1'b1, addr: addr, data: data};
      @(posedge clk_sys);
      #1 reg_wr <= '{en: 1'b0, addr: ~addr, data: ~data};
   endtask

   // A clear bit is written back to zero at once, so a later write cannot repeat the clear.
   task automatic clear_flags(input logic [7:0] bits, input logic [7:0] keep);
      write(ADDR_PILOT_IRQ, bits | keep);
      write(ADDR_PILOT_IRQ, keep);
   endtask

   // Each change of the toggle loads one group.
   task automatic load_group();
      @(posedge clk_sys);
      #1 group_load_toggle <= ~group_load_toggle;
   endtask
endmodule

`default_nettype wire

/* tb/test_fm_tx_deviation_irq_control.sv */
// Self-checking testbench for the deviation, pilot gain and interrupt control bank.
`timescale 1ns/100ps
`default_nettype none

module test_fm_tx_deviation_irq_control;
   import fm_ctrl_pkg::*;
   // A short pulse keeps the run brief; every nonzero pulse length expected is taken from this value.
   localparam int unsigned PLEN = 8;
   logic          clk_sys = 1'b0;
   logic          rst_n = 1'b0;
   logic          tx_mode = 1'b0;
   logic [3:0]    ev = 4'h0;
   reg_write_type reg_wr;
   logic          group_load_toggle;
   config_type    cfg;
   logic          underrun_flag;
   logic          overrun_flag;
   logic          group_readable;
   logic          rx_int_out;
   logic          rx_int_oe;
   logic          tx_int_out;
   logic          tx_int_oe;
   int            n_mismatch = 0;
   int            checks_done = 0;

   // The clock runs at 50 MHz.
   always #10 clk_sys = ~clk_sys;

   host_ctrl_model host_ctrl_model_i (.clk_sys(clk_sys), .reg_wr(reg_wr),
      .group_load_toggle(group_load_toggle));

   fm_tx_deviation_irq_control #(.PULSE_LEN(PLEN)) fm_tx_deviation_irq_control_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .tx_mode(tx_mode),
      .group_load_toggle(group_load_toggle), .rx_group_stored(ev[1]), .scan_done(ev[0]),
      .underrun_event(ev[2]), .overrun_event(ev[3]), .cfg(cfg), .underrun_flag(underrun_flag),
      .overrun_flag(overrun_flag), .group_readable(group_readable), .rx_int_out(rx_int_out),
      .rx_int_oe(rx_int_oe), .tx_int_out(tx_int_out), .tx_int_oe(tx_int_oe));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // Event inputs are one-cycle pulses.
   task automatic fire(input logic [3:0] m);
      @(posedge clk_sys);
      #1 ev = m;
      @(posedge clk_sys);
      #1 ev = 4'h0;
   endtask

   function automatic logic pin(input logic on_tx);
      return on_tx ? tx_int_out : rx_int_out;
   endfunction

   // Waits a bounded time for a low pulse and counts its cycles; zero means no pulse came.
   task automatic irq_len(input logic on_tx, input int unsigned exp);
      int unsigned n;
      n = 0;
      for (int w = 0; w < 6 && pin(on_tx) !== 1'b0; w++)
      begin
         @(posedge clk_sys);
         #1;
      end
      while (pin(on_tx) === 1'b0 && n < 40)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n == 40)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: pulse never ended", $time);
         give_verdict();
      end
      chk(8'(n), 8'(exp), "pulse length");
      chk(8'(pin(on_tx)), 8'h01, "pin idle");
      chk(8'({rx_int_oe, tx_int_oe}), 8'({~on_tx, on_tx}), "pin select");
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      repeat (2) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      chk(cfg.tx_deviation, 8'h6C, "deviation reset");
      chk(8'({cfg.group_irq_en, cfg.scan_irq_en, underrun_flag, overrun_flag}), 8'h00,
          "resets");
      @(posedge clk_sys);
      #1;
      chk(8'({rx_int_out, rx_int_oe, tx_int_out, tx_int_oe}), 8'h0E, "reset pins");
      $display("test reset finished");
      host_ctrl_model_i.write(ADDR_TX_DEVIATION, 8'h00);
      chk(cfg.tx_deviation, 8'h00, "deviation low");
      host_ctrl_model_i.write(ADDR_TX_DEVIATION, 8'hFF);
      chk(cfg.tx_deviation, 8'hFF, "deviation high");
      host_ctrl_model_i.write(8'h20, 8'h5A);
      chk(cfg.tx_deviation, 8'hFF, "unmapped write");
      for (int g = 7; g <= 10; g++)
      begin
         host_ctrl_model_i.write(ADDR_PILOT_IRQ, 8'(g << 2));
         chk(8'(cfg.pilot_gain), 8'(g), "pilot gain");
      end
      $display("test registers finished");
      // Each flag is set, survives a write with its clear bit at zero, then clears.
      for (int f = 0; f < 2; f++)
      begin
         fire(f ? 4'h8 : 4'h4);
         chk(8'(f ? overrun_flag : underrun_flag), 8'h01, "flag set");
         host_ctrl_model_i.write(ADDR_PILOT_IRQ, 8'h28);
         chk(8'(f ? overrun_flag : underrun_flag), 8'h01, "zero no action");
         host_ctrl_model_i.clear_flags(f ? 8'h40 : 8'h80, 8'h28);
         chk(8'(f ? overrun_flag : underrun_flag), 8'h00, "flag cleared");
      end
      $display("test flags finished");
      fire(4'h1);
      irq_len(1'b0, 0);
      host_ctrl_model_i.write(ADDR_PILOT_IRQ, 8'h25);
      fire(4'h1);
      irq_len(1'b0, PLEN);
      fire(4'h2);
      irq_len(1'b0, 0);
      host_ctrl_model_i.write(ADDR_PILOT_IRQ, 8'h27);
      fire(4'h2);
      irq_len(1'b0, PLEN);
      $display("test receive interrupts finished");
      @(posedge clk_sys);
      #1 tx_mode = 1'b1;
      host_ctrl_model_i.write(ADDR_GROUP_FIRST, 8'h33);
      chk(8'(group_readable), 8'h00, "group hidden");
      host_ctrl_model_i.write(ADDR_GROUP_LAST, 8'h44);
      chk(8'(group_readable), 8'h00, "group still hidden");
      host_ctrl_model_i.load_group();
      @(posedge clk_sys);
      #1 chk(8'(group_readable), 8'h01, "group loaded");
      irq_len(1'b1, PLEN);
      // A second scan during a pulse gives one more pulse after one high cycle.
      // The second request lands in the first low cycle, so that cycle is gone when counting.
      fire(4'h1);
      fire(4'h1);
      irq_len(1'b1, PLEN - 1);
      irq_len(1'b1, PLEN);
      $display("test transmit interrupts finished");
      give_verdict();
   end
endmodule

`default_nettype wire
